// File: inc/clock_dist_pkg.sv
package clock_dist_pkg;

  localparam int          ADDR_W         = 7;
  localparam int          DATA_W         = 8;
  localparam int          REG_DEPTH      = 96;
  localparam int          NUM_OUT        = 8;
  localparam int          NUM_ECL        = 4;

  localparam logic [6:0]  SYNC_CTRL_ADDR = 7'h58;
  localparam logic [6:0]  UNUSED_ADDR    = 7'h59;
  localparam logic [6:0]  UPDATE_ADDR    = 7'h5a;
  localparam logic [6:0]  PLL_PD_ADDR    = 7'h0a;
  localparam logic [6:0]  DIST_PD_ADDR   = 7'h45;
  localparam logic [6:0]  OUT_CTRL_BASE  = 7'h3c;
  localparam logic [6:0]  DIV_CTRL_BASE  = 7'h49;
  localparam logic [6:0]  DELAY_A_ADDR   = 7'h34;
  localparam logic [6:0]  DELAY_B_ADDR   = 7'h38;

  localparam int          SOFT_SYNC_BIT  = 2;
  localparam int          SYNC_PD_BIT    = 4;
  localparam int          PIN_SEL_LSB    = 5;
  localparam int          UPDATE_BIT     = 0;
  localparam int          PLL_PD_BIT     = 0;
  localparam int          DIST_PD_BIT    = 1;
  localparam int          DIV_BYPASS_BIT = 7;
  localparam int          DELAY_OFF_BIT  = 0;
  localparam int          DELAY_A_OUT    = 5;
  localparam int          DELAY_B_OUT    = 6;

  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam logic [7:0]  SYNC_CTRL_MASK = 8'h7f;

  localparam logic [4:0]  INSTR_LAST     = 5'h0f;
  localparam logic [4:0]  DATA_LAST      = 5'h07;
  localparam logic [4:0]  DATA_BITS      = 5'h08;

  typedef enum logic [1:0] {
    pin_reset_low_role     = 2'b00,
    pin_sync_low_role      = 2'b01,
    pin_test_role          = 2'b10,
    pin_powerdown_low_role = 2'b11
  } pin_role_t;

  typedef enum logic [1:0] {
    SP_IDLE  = 2'b00,
    SP_INSTR = 2'b01,
    SP_WDATA = 2'b10,
    SP_RDATA = 2'b11
  } sport_state_t;

  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic               chip_pd;
    logic               pll_pd;
    logic               dist_pd;
    logic               sync_pd;
    logic [NUM_OUT-1:0] div_pd;
    logic [1:0]         delay_pd;
    logic [NUM_OUT-1:0] out_pd;
    logic [NUM_ECL-1:0] ecl_full_off;
  } power_ctrl_t;

  typedef struct packed {
    logic hold;
    logic pulse;
    logic resync_needed;
  } sync_ctrl_t;

endpackage : clock_dist_pkg

// File: rtl/serial_port_engine.sv
`timescale 1ns/1ns
`default_nettype none

// single-byte transfers: 16-bit instruction (bit 15 = read, bits 6:0 address) then 8 data bits
module serial_port_engine (
  input  wire logic                          clock,
  input  wire logic                          arst_n,
  input  wire logic                          sclk,
  input  wire logic                          csb_n,
  input  wire logic                          sdio_in,
  output logic                               sdio_out,
  output logic                               sdio_oe_n,
  output logic                               sclk_rise,
  output clock_dist_pkg::reg_req_t           req,
  output logic [clock_dist_pkg::ADDR_W-1:0]  rd_addr,
  input  wire logic [clock_dist_pkg::DATA_W-1:0] rdata
);

  clock_dist_pkg::sport_state_t state, next_state;
  logic [4:0]  cnt,      next_cnt;
  logic [15:0] sh,       next_sh;
  logic        sclk_q;
  logic        sdo_q,    next_sdo;
  logic        oe_n_q,   next_oe_n;
  clock_dist_pkg::reg_req_t req_q, next_req;
  logic        sclk_fall;

  assign sclk_rise = sclk & ~sclk_q;
  assign sclk_fall = ~sclk & sclk_q;

  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_sh         = sh;
    next_sdo        = sdo_q;
    next_oe_n       = oe_n_q;
    next_req        = req_q;
    next_req.wr     = 1'b0;
    case (state)
      clock_dist_pkg::SP_IDLE: begin
        next_state = clock_dist_pkg::SP_INSTR;
        next_cnt   = 5'h00;
      end
      clock_dist_pkg::SP_INSTR: begin
        if (sclk_rise) begin
          next_sh  = {sh[14:0], sdio_in};
          next_cnt = cnt + 5'h01;
          if (cnt == clock_dist_pkg::INSTR_LAST) begin
            next_req.addr = next_sh[clock_dist_pkg::ADDR_W-1:0];
            next_cnt      = 5'h00;
            next_state    = next_sh[15] ? clock_dist_pkg::SP_RDATA : clock_dist_pkg::SP_WDATA;
          end
        end
      end
      clock_dist_pkg::SP_WDATA: begin
        if (sclk_rise) begin
          next_sh  = {sh[14:0], sdio_in};
          next_cnt = cnt + 5'h01;
          if (cnt == clock_dist_pkg::DATA_LAST) begin
            next_req.wr    = 1'b1;
            next_req.wdata = next_sh[7:0];
            next_cnt       = 5'h00;
            next_state     = clock_dist_pkg::SP_INSTR;
          end
        end
      end
      clock_dist_pkg::SP_RDATA: begin
        // data leaves on falling edges so the host samples it stable on rising ones
        if (sclk_fall && cnt != clock_dist_pkg::DATA_BITS) begin
          next_oe_n = 1'b0;
          next_cnt  = cnt + 5'h01;
          if (cnt == 5'h00) begin
            next_sdo      = rdata[7];
            next_sh[7:0]  = {rdata[6:0], 1'b0};
          end else begin
            next_sdo      = sh[7];
            next_sh[7:0]  = {sh[6:0], 1'b0};
          end
        end
      end
      default: next_state = clock_dist_pkg::SP_IDLE;
    endcase
    if (csb_n) begin
      next_state = clock_dist_pkg::SP_IDLE;
      next_cnt   = 5'h00;
      next_oe_n  = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state  <= clock_dist_pkg::SP_IDLE;
      cnt    <= 5'h00;
      sh     <= 16'h0000;
      sclk_q <= 1'b0;
      sdo_q  <= 1'b0;
      oe_n_q <= 1'b1;
      req_q  <= '0;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      sh     <= next_sh;
      sclk_q <= sclk;
      sdo_q  <= next_sdo;
      oe_n_q <= next_oe_n;
      req_q  <= next_req;
    end
  end

  assign sdio_out  = sdo_q;
  assign sdio_oe_n = oe_n_q;
  assign req       = req_q;
  assign rd_addr   = req_q.addr;

endmodule : serial_port_engine

`default_nettype wire

// File: rtl/clock_dist_power_sync_ctrl.sv
// Summary of operation
// - Setting bit 4 of the sync control register at 0x58 powers down the sync circuitry, default zero.
// - Bits 6:5 of 0x58 pick the multi-purpose pin role: 00 reset, 01 sync, 11 power-down; 10 is test only.
// - Writing one to bit 0 of 0x5a copies all buffered values to the active registers on the next serial clock rise.
// - The update bit clears itself once the copy is done.
// - The PLL section can be powered down by a register bit.
// - A bypassed output divider is powered down and the output runs at divide-by-one.
// - The fine-delay blocks on the two delay-capable outputs are powered down when not selected.
// - Each output can be powered down, and emitter-coupled outputs have a safe state and a fully off state.
// - The whole distribution section can be powered down as one unit.
// - Powering a block down and up keeps its register contents.
// - Any power-down other than the sync power-down loses output alignment until a sync event is issued.
// - In sync role a low pin holds outputs and its rising edge syncs; the soft sync bit does the same inverted.
`timescale 1ns/1ns
`default_nettype none

module clock_dist_power_sync_ctrl (
  input  wire logic                        clock,
  input  wire logic                        arst_n,
  input  wire logic                        sclk,
  input  wire logic                        csb_n,
  input  wire logic                        sdio_in,
  output logic                             sdio_out,
  output logic                             sdio_oe_n,
  input  wire logic                        function_pin,
  output clock_dist_pkg::pin_role_t        pin_role,
  output clock_dist_pkg::power_ctrl_t      power,
  output clock_dist_pkg::sync_ctrl_t       sync
);

  localparam int DEPTH = clock_dist_pkg::REG_DEPTH;

  logic [7:0] buf_q    [DEPTH];
  logic [7:0] next_buf [DEPTH];
  logic [7:0] act_q    [DEPTH];
  logic [7:0] next_act [DEPTH];
  logic       pending,      next_pending;
  logic       pin_q,        next_pin_q;
  logic       soft_q,       next_soft_q;
  logic       unsync_q,     next_unsync;
  logic       pd_prev_q;
  clock_dist_pkg::power_ctrl_t power_q, power_d;
  clock_dist_pkg::sync_ctrl_t  sync_q,  sync_d;
  clock_dist_pkg::pin_role_t   role;

  clock_dist_pkg::reg_req_t               req;
  logic [clock_dist_pkg::ADDR_W-1:0]      rd_addr;
  logic [clock_dist_pkg::DATA_W-1:0]      rdata;
  logic                                   sclk_rise;
  logic                                   pin_reset;
  logic                                   soft_sync;
  logic                                   pd_any;

  serial_port_engine u_sport (
    .clock     (clock),
    .arst_n    (arst_n),
    .sclk      (sclk),
    .csb_n     (csb_n),
    .sdio_in   (sdio_in),
    .sdio_out  (sdio_out),
    .sdio_oe_n (sdio_oe_n),
    .sclk_rise (sclk_rise),
    .req       (req),
    .rd_addr   (rd_addr),
    .rdata     (rdata)
  );

  // pin role follows the active copy, so a new role only takes hold after an update
  assign role = clock_dist_pkg::pin_role_t'(
    act_q[clock_dist_pkg::SYNC_CTRL_ADDR][clock_dist_pkg::PIN_SEL_LSB +: 2]);
  assign pin_reset = (role == clock_dist_pkg::pin_reset_low_role) && !function_pin;
  assign soft_sync = act_q[clock_dist_pkg::SYNC_CTRL_ADDR][clock_dist_pkg::SOFT_SYNC_BIT];

  // readback shows the buffered copy; the update bit shows whether a copy is still armed
  always_comb begin
    rdata = 8'h00;
    if (rd_addr == clock_dist_pkg::UPDATE_ADDR) begin
      rdata = {7'h00, pending};
    end else if (int'(rd_addr) < DEPTH) begin
      rdata = buf_q[rd_addr];
    end
  end

  // register bank: writes land in the buffer, the update moves them to the active copy
  always_comb begin
    next_buf     = buf_q;
    next_act     = act_q;
    next_pending = pending;
    if (pending && sclk_rise) begin
      next_act     = buf_q;
      next_pending = 1'b0;
    end
    if (req.wr && int'(req.addr) < DEPTH) begin
      if (req.addr == clock_dist_pkg::UPDATE_ADDR) begin
        if (req.wdata[clock_dist_pkg::UPDATE_BIT]) begin
          next_pending = 1'b1;
        end
      end else if (req.addr == clock_dist_pkg::SYNC_CTRL_ADDR) begin
        next_buf[req.addr] = req.wdata & clock_dist_pkg::SYNC_CTRL_MASK;
      end else if (req.addr != clock_dist_pkg::UNUSED_ADDR) begin
        next_buf[req.addr] = req.wdata;
      end
    end
    // power-down never touches the bank; only the reset role clears it
    if (pin_reset) begin
      for (int k = 0; k < DEPTH; k++) begin
        next_buf[k] = clock_dist_pkg::REG_RESET;
        next_act[k] = clock_dist_pkg::REG_RESET;
      end
      next_pending = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int k = 0; k < DEPTH; k++) begin
        buf_q[k] <= clock_dist_pkg::REG_RESET;
        act_q[k] <= clock_dist_pkg::REG_RESET;
      end
      pending <= 1'b0;
    end else begin
      buf_q   <= next_buf;
      act_q   <= next_act;
      pending <= next_pending;
    end
  end

  // power control decode, one slice per output
  logic [clock_dist_pkg::NUM_OUT-1:0] out_off;
  logic [clock_dist_pkg::NUM_OUT-1:0] div_off;
  logic [clock_dist_pkg::NUM_ECL-1:0] ecl_off;
  logic                               chip_pd;
  logic                               dist_pd;

  assign chip_pd = (role == clock_dist_pkg::pin_powerdown_low_role) && !function_pin;
  assign dist_pd = act_q[clock_dist_pkg::DIST_PD_ADDR][clock_dist_pkg::DIST_PD_BIT] | chip_pd;

  genvar i;
  generate
    for (i = 0; i < clock_dist_pkg::NUM_OUT; i++) begin : g_out
      localparam logic [6:0] OUT_A = clock_dist_pkg::OUT_CTRL_BASE + 7'(i);
      localparam logic [6:0] DIV_A = clock_dist_pkg::DIV_CTRL_BASE + 7'(2 * i);
      // any non-zero mode turns the output off
      assign out_off[i] = (act_q[OUT_A][1:0] != 2'b00) | dist_pd;
      // bypass means divide-by-one with the clock routed past the divider
      assign div_off[i] = act_q[DIV_A][clock_dist_pkg::DIV_BYPASS_BIT] | dist_pd;
      if (i < clock_dist_pkg::NUM_ECL) begin : g_ecl
        // mode 01 is the safe state; mode 1x cuts the stage fully and is unsafe when terminated
        assign ecl_off[i] = act_q[OUT_A][1] | dist_pd;
      end
    end
  endgenerate

  always_comb begin
    power_d              = '0;
    power_d.chip_pd      = chip_pd;
    power_d.pll_pd       = act_q[clock_dist_pkg::PLL_PD_ADDR][clock_dist_pkg::PLL_PD_BIT]
                           | chip_pd;
    power_d.dist_pd      = dist_pd;
    power_d.sync_pd      = act_q[clock_dist_pkg::SYNC_CTRL_ADDR][clock_dist_pkg::SYNC_PD_BIT]
                           | chip_pd;
    power_d.div_pd       = div_off;
    power_d.out_pd       = out_off;
    power_d.ecl_full_off = ecl_off;
    // a delay block idles when deselected or when its output is off
    power_d.delay_pd[0]  = act_q[clock_dist_pkg::DELAY_A_ADDR][clock_dist_pkg::DELAY_OFF_BIT]
                           | out_off[clock_dist_pkg::DELAY_A_OUT];
    power_d.delay_pd[1]  = act_q[clock_dist_pkg::DELAY_B_ADDR][clock_dist_pkg::DELAY_OFF_BIT]
                           | out_off[clock_dist_pkg::DELAY_B_OUT];
  end

  assign pd_any = power_d.chip_pd | power_d.pll_pd | power_d.dist_pd
                  | (|power_d.div_pd) | (|power_d.out_pd) | (|power_d.delay_pd);

  // sync events; a powered-down sync circuit ignores both sources
  always_comb begin
    sync_d       = '0;
    next_pin_q   = function_pin;
    next_soft_q  = soft_sync;
    next_unsync  = unsync_q;
    if (!power_d.sync_pd) begin
      sync_d.hold  = ((role == clock_dist_pkg::pin_sync_low_role) && !function_pin)
                     | soft_sync;
      sync_d.pulse = ((role == clock_dist_pkg::pin_sync_low_role) && function_pin && !pin_q)
                     | (!soft_sync && soft_q);
    end
    if (sync_d.pulse) begin
      next_unsync = 1'b0;
    end
    // a new power-down wins over a sync in the same cycle
    if (pd_any && !pd_prev_q) begin
      next_unsync = 1'b1;
    end
    sync_d.resync_needed = next_unsync;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_q     <= 1'b1;
      soft_q    <= 1'b0;
      unsync_q  <= 1'b0;
      pd_prev_q <= 1'b0;
      power_q   <= '0;
      sync_q    <= '0;
    end else begin
      pin_q     <= next_pin_q;
      soft_q    <= next_soft_q;
      unsync_q  <= next_unsync;
      pd_prev_q <= pd_any;
      power_q   <= power_d;
      sync_q    <= sync_d;
    end
  end

  assign power    = power_q;
  assign sync     = sync_q;
  assign pin_role = role;

endmodule : clock_dist_power_sync_ctrl

`default_nettype wire

// File: test/clock_dist_power_sync_ctrl_properties.sv
`timescale 1ns/1ns
`default_nettype none

module power_sync_checker (
  input wire logic                        clock,
  input wire logic                        arst_n,
  input wire logic                        sclk,
  input wire logic                        csb_n,
  input wire logic                        sdio_in,
  input wire logic                        sdio_out,
  input wire logic                        sdio_oe_n,
  input wire logic                        function_pin,
  input wire clock_dist_pkg::pin_role_t   pin_role,
  input wire clock_dist_pkg::power_ctrl_t power,
  input wire clock_dist_pkg::sync_ctrl_t  sync
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  logic any_pd;
  // sync power-down is left out: it does not disturb divider alignment
  assign any_pd = power.chip_pd | power.pll_pd | power.dist_pd | (|power.div_pd)
                  | (|power.delay_pd) | (|power.out_pd);

  property p_sync_pd_quiet;
    power.sync_pd |-> !sync.hold && !sync.pulse;
  endproperty
  a_sync_pd_quiet: assert property (p_sync_pd_quiet) else $error("sync active while powered down");

  property p_chip_pd;
    power.chip_pd |-> power.pll_pd && power.dist_pd && power.sync_pd;
  endproperty
  a_chip_pd: assert property (p_chip_pd) else $error("chip power-down incomplete");

  property p_pd_role;
    pin_role == clock_dist_pkg::pin_powerdown_low_role && !function_pin |=> power.chip_pd;
  endproperty
  a_pd_role: assert property (p_pd_role) else $error("low pin did not power down");

  property p_reset_role;
    (pin_role == clock_dist_pkg::pin_reset_low_role && !function_pin) [*2] |=> power == '0;
  endproperty
  a_reset_role: assert property (p_reset_role) else $error("pin reset left power bits");

  property p_pin_hold;
    pin_role == clock_dist_pkg::pin_sync_low_role && !function_pin |=> sync.hold || power.sync_pd;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("low pin did not hold outputs");

  property p_rise_pulse;
    $rose(function_pin) && sync.hold && pin_role == clock_dist_pkg::pin_sync_low_role
      |=> sync.pulse || power.sync_pd;
  endproperty
  a_rise_pulse: assert property (p_rise_pulse) else $error("pin rise gave no pulse");

  property p_pulse_once;
    sync.pulse |=> !sync.pulse;
  endproperty
  a_pulse_once: assert property (p_pulse_once) else $error("sync pulse too long");

  property p_resync_set;
    $rose(any_pd) |-> ##[0:1] sync.resync_needed;
  endproperty
  a_resync_set: assert property (p_resync_set) else $error("resync flag not set");

  property p_oe_idle;
    csb_n [*3] |-> sdio_oe_n;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("sdio driven while deselected");

  c_chip_pd: cover property (power.chip_pd);
  c_pulse:   cover property (sync.pulse);
  c_read:    cover property (!sdio_oe_n);
endmodule : power_sync_checker

bind clock_dist_power_sync_ctrl power_sync_checker u_chk (
  .clock(clock), .arst_n(arst_n), .sclk(sclk), .csb_n(csb_n), .sdio_in(sdio_in),
  .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .function_pin(function_pin),
  .pin_role(pin_role), .power(power), .sync(sync)
);

`default_nettype wire

// File: test/host_port_model.sv
`timescale 1ns/1ns
`default_nettype none

module host_port_model (
  input  wire logic clock,
  input  wire logic sdio_out,
  input  wire logic sdio_oe_n,
  output var logic  sclk,
  output var logic  csb_n,
  output var logic  sdio_in
);
  // called at time zero so the port sits deselected through reset
  task automatic idle;
    sclk = 1'b0;
    csb_n = 1'b1;
    sdio_in = 1'b0;
  endtask : idle

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : wait_clk

  // sclk idles low; 3 clocks a phase keeps above the 2-clock minimum
  task automatic frame(input logic rd, input logic [6:0] addr,
                       input logic [7:0] wdata, output logic [7:0] rdata);
    logic [23:0] bits;
    bits = {rd, 8'h00, addr, wdata};
    rdata = 8'h00;
    csb_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sclk = 1'b0;
      // a released line toggles so that a stray sample never looks stable
      sdio_in = (rd && i < 8) ? ~sdio_in : bits[i];
      wait_clk(3);
      if (rd && i < 8) rdata[i] = (sdio_oe_n === 1'b0) ? sdio_out : 1'bx;
      sclk = 1'b1;
      wait_clk(3);
    end
    sclk = 1'b0;
    csb_n = 1'b1;
    sdio_in = ~sdio_in;
    wait_clk(3);
  endtask : frame
endmodule : host_port_model

`default_nettype wire

// File: test/clock_dist_power_sync_ctrl_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module clock_dist_power_sync_ctrl_tb_top;
  logic                        clock = 1'b0;
  logic                        arst_n = 1'b0;
  logic                        function_pin = 1'b1;
  wire logic                   sclk, csb_n, sdio_in, sdio_out, sdio_oe_n;
  clock_dist_pkg::pin_role_t   pin_role;
  clock_dist_pkg::power_ctrl_t power;
  clock_dist_pkg::sync_ctrl_t  sync;
  int                          n_fail = 0;
  int                          compares = 0;
  int                          n_pulse = 0;

  always #25 clock = ~clock;
  always @(posedge clock) if (sync.pulse === 1'b1) n_pulse++;

  clock_dist_power_sync_ctrl DUT (
    .clock(clock), .arst_n(arst_n), .sclk(sclk), .csb_n(csb_n), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .function_pin(function_pin),
    .pin_role(pin_role), .power(power), .sync(sync)
  );
  host_port_model host (
    .clock(clock), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
    .sclk(sclk), .csb_n(csb_n), .sdio_in(sdio_in)
  );

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    host.frame(1'b0, a, d, r);
  endtask : wr

  task automatic rd_chk(input string what, input logic [6:0] a, input logic [7:0] e);
    logic [7:0] r;
    host.frame(1'b1, a, 8'h00, r);
    check(what, e, r);
  endtask : rd_chk

  // the read frame's first sclk rise performs the transfer
  task automatic upd;
    wr(7'h5a, 8'h01);
    rd_chk("update bit", 7'h5a, 8'h00);
    host.wait_clk(2);
  endtask : upd

  task automatic t_defaults;
    rd_chk("sync ctrl", 7'h58, 8'h00);
    wr(7'h59, 8'hff);
    rd_chk("unused", 7'h59, 8'h00);
    rd_chk("beyond map", 7'h60, 8'h00);
    check("power", 0, power);
    $display("defaults done");
  endtask : t_defaults

  task automatic t_update;
    wr(7'h0a, 8'h01);
    host.wait_clk(4);
    check("pll pd early", 0, power.pll_pd);
    rd_chk("pll buffer", 7'h0a, 8'h01);
    check("pll pd still", 0, power.pll_pd);
    upd;
    check("pll pd", 1, power.pll_pd);
    wr(7'h0a, 8'h00);
    upd;
    check("pll pd off", 0, power.pll_pd);
    $display("update done");
  endtask : t_update

  task automatic t_blocks;
    wr(7'h49, 8'h80);
    wr(7'h57, 8'h80);
    wr(7'h34, 8'h01);
    wr(7'h38, 8'h01);
    wr(7'h3c, 8'h01);
    wr(7'h3d, 8'h02);
    wr(7'h43, 8'h01);
    upd;
    check("divider pd", 8'h81, power.div_pd);
    check("delay pd", 2'b11, power.delay_pd);
    check("dist up", 0, power.dist_pd);
    check("out pd", 8'h83, power.out_pd);
    check("full off", 4'b0010, power.ecl_full_off);
    // distribution power-down drags every divider down with it
    wr(7'h45, 8'h02);
    upd;
    check("dist pd", 1, power.dist_pd);
    check("dist divider pd", 8'hff, power.div_pd);
    check("resync", 1, sync.resync_needed);
    $display("blocks done");
  endtask : t_blocks

  task automatic t_pin_reset;
    function_pin = 1'b0;
    host.wait_clk(3);
    function_pin = 1'b1;
    host.wait_clk(2);
    check("power after pin reset", 0, power);
    rd_chk("divider reg", 7'h49, 8'h00);
    $display("pin reset done");
  endtask : t_pin_reset

  task automatic t_roles;
    logic [7:0] v [3] = '{8'h80, 8'h20, 8'h60};
    foreach (v[i]) begin
      wr(7'h58, v[i]);
      upd;
      check("pin role", {30'h0, v[i][6:5]}, pin_role);
      rd_chk("sync ctrl mask", 7'h58, v[i] & 8'h7f);
    end
    function_pin = 1'b0;
    host.wait_clk(3);
    check("chip pd", 1, power.chip_pd);
    function_pin = 1'b1;
    host.wait_clk(3);
    check("chip up", 0, power.chip_pd);
    rd_chk("role kept", 7'h58, 8'h60);
    $display("roles done");
  endtask : t_roles

  task automatic t_sync;
    int n;
    wr(7'h58, 8'h20);
    upd;
    n = n_pulse;
    check("resync set", 1, sync.resync_needed);
    function_pin = 1'b0;
    host.wait_clk(3);
    check("hold", 1, sync.hold);
    function_pin = 1'b1;
    host.wait_clk(3);
    check("pin pulses", n + 1, n_pulse);
    check("resync cleared", 0, sync.resync_needed);
    wr(7'h58, 8'h24);
    upd;
    check("soft hold", 1, sync.hold);
    wr(7'h58, 8'h20);
    upd;
    check("soft pulses", n + 2, n_pulse);
    wr(7'h58, 8'h34);
    upd;
    check("sync pd", 1, power.sync_pd);
    check("hold suppressed", 0, sync.hold);
    $display("sync done");
  endtask : t_sync

  task automatic tally_and_finish;
    $display("compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (50000) @(posedge clock);
    n_fail++;
    tally_and_finish;
  end

  initial begin
    host.idle;
    repeat (6) @(posedge clock);
    #2 arst_n = 1'b1;
    host.wait_clk(2);
    t_defaults;
    t_update;
    t_blocks;
    t_pin_reset;
    t_roles;
    t_sync;
    tally_and_finish;
  end
endmodule : clock_dist_power_sync_ctrl_tb_top

`default_nettype wire
